/* File: rtl/cff_regs.vh */
// Register map, field positions, reset values and sizes of the channel FIFO block.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
`ifndef CFF_REGS_VH
`define CFF_REGS_VH

// Sizes
`define CFF_NCH        4
`define CFF_DEPTH      17'd32768
`define CFF_AW         15
`define CFF_CW         16

// Channel window: channel n at n * CFF_CH_STRIDE, word offsets below
`define CFF_CH_STRIDE  12'h020
`define CFF_OFF_DATA   3'h0
`define CFF_OFF_CSR    3'h1
`define CFF_OFF_ALMOST 3'h2
`define CFF_OFF_TXCNT  3'h3
`define CFF_OFF_RXCNT  3'h4

// Board registers (byte addresses)
`define CFF_BRD_CTRL   12'h100
`define CFF_BRD_SIZE   12'h104
`define CFF_INT_STAT   12'h108
`define CFF_INT_MASK   12'h10c

// Channel control/status fields
`define CFF_CSR_TXF    3:0
`define CFF_CSR_RXF    7:4
`define CFF_CSR_TXRST  8
`define CFF_CSR_RXRST  9
// Flag positions inside a 4-bit group, all active low
`define CFF_F_EMPTY    0
`define CFF_F_FULL     1
`define CFF_F_AEMPTY   2
`define CFF_F_AFULL    3
// Board control fields
`define CFF_BRD_RST    0

// Reset values
`define CFF_ALMOST_RST 32'h00070007
`define CFF_FLAGS_RST  4'ha

`endif

/* File: rtl/cff_top.v */
// Channel FIFO block: per channel a 32k byte transmit and receive FIFO, flags,
// fill counters, thresholds, size report and a board-wide interrupt.
// Assumes a classic Wishbone master on clk_i and a serial byte DMA on clk_i.
//
// Notes on behaviour
// - Every FIFO offers empty, full, almost-empty, almost-full flags, readable anytime.
// - The four flags read active low: zero means the condition holds.
// - Empty holds at zero bytes, full holds at full capacity.
// - Almost-empty holds while byte count is at most the almost-empty value.
// - Almost-full holds while byte count is at least size minus almost-full value.
// - Threshold register resets to seven in both halves.
// - With seven, almost-empty changes between seven and eight stored bytes.
// - New thresholds act at once; software should set them on an empty FIFO.
// - Each FIFO counter shows the exact byte count, updated in real time.
// - After every board reset the FIFO depth is detected and reported.
// - Every FIFO is 32k bytes deep.
// - Board reset restores control registers and empties all FIFOs.
// - One board-wide interrupt control with separate bits per channel flag.
// - One data address per channel: write pushes transmit, read pops receive.
// - A FIFO reset bit empties that FIFO at once, sparing its partner.
// - Every flag is also an interrupt source.
//
// Implementation choices: register access over Wishbone and the register addresses.
`include "cff_regs.vh"
`timescale 1ns/10ps
`default_nettype none

module cff_top (
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [11:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg         irq_o,
  // Serial side, transmit drain
  input  wire [3:0]  tx_pop_i,
  output reg  [31:0] tx_data_o,
  output reg  [3:0]  tx_valid_o,
  output reg  [3:0]  tx_avail_o,
  // Serial side, receive fill
  input  wire [3:0]  rx_push_i,
  input  wire [31:0] rx_data_i,
  output reg  [3:0]  rx_space_o
);

  // Storage: channel index in the upper address bits
  reg [7:0]            tx_mem [0:4*32768-1];
  reg [7:0]            rx_mem [0:4*32768-1];
  reg [`CFF_AW-1:0]    tx_wp_reg [0:3];
  reg [`CFF_AW-1:0]    tx_rp_reg [0:3];
  reg [`CFF_AW-1:0]    rx_wp_reg [0:3];
  reg [`CFF_AW-1:0]    rx_rp_reg [0:3];
  reg [`CFF_CW-1:0]    tx_cnt_reg [0:3];
  reg [`CFF_CW-1:0]    rx_cnt_reg [0:3];
  reg [`CFF_CW-1:0]    tx_cnt_next [0:3];
  reg [`CFF_CW-1:0]    rx_cnt_next [0:3];
  reg [31:0]           almost_reg [0:3];
  reg [31:0]           almost_next [0:3];
  reg [3:0]            txf_reg [0:3];
  reg [3:0]            rxf_reg [0:3];
  reg [3:0]            txf_next [0:3];
  reg [3:0]            rxf_next [0:3];
  reg [31:0]           int_stat_reg;
  reg [31:0]           int_mask_reg;
  reg [31:0]           int_set;
  reg [16:0]           size_reg;
  reg                  soft_rst_reg;
  reg [3:0]            tx_push;
  reg [3:0]            tx_pop;
  reg [3:0]            rx_push;
  reg [3:0]            rx_pop;
  reg [3:0]            tx_clr;
  reg [3:0]            rx_clr;
  reg [31:0]           rdata;

  // Bus decode: a request is served once, on the edge that raises ack
  wire       acc     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire       wr      = acc & wb_we_i;
  wire       rd      = acc & ~wb_we_i;
  wire       ch_win  = (wb_adr_i[11:7] == 5'h00);
  wire [1:0] ch_sel  = wb_adr_i[6:5];
  wire [2:0] ch_off  = wb_adr_i[4:2];
  wire       brst    = rst_i | soft_rst_reg;

  // Active-low flag vector for a byte count and threshold pair
  function [3:0] flag_n;
    input [15:0] cnt;
    input [15:0] ae;
    input [15:0] af;
    begin
      flag_n[`CFF_F_EMPTY]  = ~({1'b0, cnt} == 17'd0);
      flag_n[`CFF_F_FULL]   = ~({1'b0, cnt} == `CFF_DEPTH);
      flag_n[`CFF_F_AEMPTY] = ~(cnt <= ae);
      flag_n[`CFF_F_AFULL]  = ~(({1'b0, cnt} + {1'b0, af}) >= `CFF_DEPTH);
    end
  endfunction

  // Byte-lane merge of a write into a 32-bit register
  function [31:0] merge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0]  sel;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        merge[k*8 +: 8] = sel[k] ? dat[k*8 +: 8] : old[k*8 +: 8];
      end
    end
  endfunction

  // Channel window hit for one channel and word offset
  function ch_hit;
    input [11:0] adr;
    input [1:0]  ch;
    input [2:0]  off;
    begin
      ch_hit = (adr[11:7] == 5'h00) & (adr[6:5] == ch) & (adr[4:2] == off);
    end
  endfunction

  // Next occupancy after one optional push and one optional pop
  function [15:0] fill_step;
    input [15:0] cnt;
    input        push;
    input        pop;
    begin
      fill_step = cnt + {15'h0000, push} - {15'h0000, pop};
    end
  endfunction

  // True while a FIFO can still take a byte
  function not_full;
    input [15:0] cnt;
    begin
      not_full = ({1'b0, cnt} != `CFF_DEPTH);
    end
  endfunction

  // Per-channel moves, counters, thresholds and flags
  always @* begin : flags_p
    integer i;
    i       = 0;
    int_set = 32'h00000000;
    for (i = 0; i < 4; i = i + 1) begin
      // Decoded strobes; a FIFO reset beats a same-cycle move
      tx_clr[i]  = wr & ch_hit(wb_adr_i, i[1:0], `CFF_OFF_CSR)
                   & wb_sel_i[1] & wb_dat_i[`CFF_CSR_TXRST];
      rx_clr[i]  = wr & ch_hit(wb_adr_i, i[1:0], `CFF_OFF_CSR)
                   & wb_sel_i[1] & wb_dat_i[`CFF_CSR_RXRST];
      tx_push[i] = wr & ch_hit(wb_adr_i, i[1:0], `CFF_OFF_DATA)
                   & wb_sel_i[0] & not_full(tx_cnt_reg[i]);
      rx_pop[i]  = rd & ch_hit(wb_adr_i, i[1:0], `CFF_OFF_DATA)
                   & (rx_cnt_reg[i] != 16'h0000);
      // Serial moves, refused when empty or full
      tx_pop[i]  = tx_pop_i[i] & (tx_cnt_reg[i] != 16'h0000);
      rx_push[i] = rx_push_i[i] & not_full(rx_cnt_reg[i]);
      // Exact occupancy, real time
      if (tx_clr[i]) begin
        tx_cnt_next[i] = 16'h0000;
      end else begin
        tx_cnt_next[i] = fill_step(tx_cnt_reg[i], tx_push[i], tx_pop[i]);
      end
      if (rx_clr[i]) begin
        rx_cnt_next[i] = 16'h0000;
      end else begin
        rx_cnt_next[i] = fill_step(rx_cnt_reg[i], rx_push[i], rx_pop[i]);
      end
      // Threshold write acts in the same cycle
      if (wr & ch_hit(wb_adr_i, i[1:0], `CFF_OFF_ALMOST)) begin
        almost_next[i] = merge(almost_reg[i], wb_dat_i, wb_sel_i);
      end else begin
        almost_next[i] = almost_reg[i];
      end
      txf_next[i] = flag_n(tx_cnt_next[i], almost_next[i][15:0], almost_next[i][31:16]);
      rxf_next[i] = flag_n(rx_cnt_next[i], almost_next[i][15:0], almost_next[i][31:16]);
      // A flag going true is an interrupt event
      int_set[i*8 +: 4]     = txf_reg[i] & ~txf_next[i];
      int_set[i*8 + 4 +: 4] = rxf_reg[i] & ~rxf_next[i];
    end
  end

  // Read data selection
  always @* begin
    rdata = 32'h00000000;
    if (ch_win) begin
      case (ch_off)
        `CFF_OFF_DATA:   rdata = {24'h000000, rx_mem[{ch_sel, rx_rp_reg[ch_sel]}]};
        `CFF_OFF_CSR:    rdata = {24'h000000, rxf_reg[ch_sel], txf_reg[ch_sel]};
        `CFF_OFF_ALMOST: rdata = almost_reg[ch_sel];
        `CFF_OFF_TXCNT:  rdata = {16'h0000, tx_cnt_reg[ch_sel]};
        `CFF_OFF_RXCNT:  rdata = {16'h0000, rx_cnt_reg[ch_sel]};
        default:         rdata = 32'h00000000;
      endcase
    end else begin
      case (wb_adr_i)
        `CFF_BRD_SIZE: rdata = {15'h0000, size_reg};
        `CFF_INT_STAT: rdata = int_stat_reg;
        `CFF_INT_MASK: rdata = int_mask_reg;
        default:       rdata = 32'h00000000;
      endcase
    end
  end

  // FIFO storage writes, no reset needed
  always @(posedge clk_i) begin : store_p
    integer i;
    for (i = 0; i < 4; i = i + 1) begin
      if (tx_push[i]) begin
        tx_mem[{i[1:0], tx_wp_reg[i]}] <= wb_dat_i[7:0];
      end
      if (rx_push[i]) begin
        rx_mem[{i[1:0], rx_wp_reg[i]}] <= rx_data_i[i*8 +: 8];
      end
    end
  end

  // Bus answer, board control, size detect and interrupt
  always @(posedge clk_i) begin
    if (brst) begin
      wb_ack_o     <= 1'b0;
      wb_dat_o     <= 32'h00000000;
      irq_o        <= 1'b0;
      int_stat_reg <= 32'h00000000;
      int_mask_reg <= 32'h00000000;
      size_reg     <= 17'd0;
      soft_rst_reg <= 1'b0;
    end else begin
      wb_ack_o     <= acc;
      wb_dat_o     <= rd ? rdata : 32'h00000000;
      // Depth report reloads on the first edge after any reset
      size_reg     <= `CFF_DEPTH;
      // Board reset request pulses for one cycle
      soft_rst_reg <= wr & (wb_adr_i == `CFF_BRD_CTRL) & wb_sel_i[0]
                      & wb_dat_i[`CFF_BRD_RST];
      // Mask takes byte-lane writes
      if (wr & (wb_adr_i == `CFF_INT_MASK)) begin
        int_mask_reg <= merge(int_mask_reg, wb_dat_i, wb_sel_i);
      end
      // Write one clears; a new event wins
      if (wr & (wb_adr_i == `CFF_INT_STAT)) begin
        int_stat_reg <= (int_stat_reg & ~merge(32'h00000000, wb_dat_i, wb_sel_i)) | int_set;
      end else begin
        int_stat_reg <= int_stat_reg | int_set;
      end
      irq_o <= |((int_stat_reg | int_set) & int_mask_reg);
    end
  end

  // Pointers, counters, thresholds, flags and serial-side outputs
  always @(posedge clk_i) begin : ptr_p
    integer i;
    for (i = 0; i < 4; i = i + 1) begin
      if (brst) begin
        // Board or hard reset empties every FIFO
        tx_wp_reg[i]   <= 15'h0000;
        tx_rp_reg[i]   <= 15'h0000;
        rx_wp_reg[i]   <= 15'h0000;
        rx_rp_reg[i]   <= 15'h0000;
        tx_cnt_reg[i]  <= 16'h0000;
        rx_cnt_reg[i]  <= 16'h0000;
        almost_reg[i]  <= `CFF_ALMOST_RST;
        // Empty and almost-empty read true
        txf_reg[i]     <= `CFF_FLAGS_RST;
        rxf_reg[i]     <= `CFF_FLAGS_RST;
        tx_data_o[i*8 +: 8] <= 8'h00;
        tx_valid_o[i]  <= 1'b0;
        tx_avail_o[i]  <= 1'b0;
        rx_space_o[i]  <= 1'b0;
      end else begin
        // A FIFO reset bit clears only its own pointers
        if (tx_clr[i]) begin
          tx_wp_reg[i] <= 15'h0000;
          tx_rp_reg[i] <= 15'h0000;
        end else begin
          tx_wp_reg[i] <= tx_wp_reg[i] + {14'h0000, tx_push[i]};
          tx_rp_reg[i] <= tx_rp_reg[i] + {14'h0000, tx_pop[i]};
        end
        if (rx_clr[i]) begin
          rx_wp_reg[i] <= 15'h0000;
          rx_rp_reg[i] <= 15'h0000;
        end else begin
          rx_wp_reg[i] <= rx_wp_reg[i] + {14'h0000, rx_push[i]};
          rx_rp_reg[i] <= rx_rp_reg[i] + {14'h0000, rx_pop[i]};
        end
        // Registered counts, thresholds and flags
        tx_cnt_reg[i] <= tx_cnt_next[i];
        rx_cnt_reg[i] <= rx_cnt_next[i];
        almost_reg[i] <= almost_next[i];
        txf_reg[i]    <= txf_next[i];
        rxf_reg[i]    <= rxf_next[i];
        // Popped byte appears one cycle after the pop
        tx_valid_o[i] <= tx_pop[i];
        if (tx_pop[i]) begin
          tx_data_o[i*8 +: 8] <= tx_mem[{i[1:0], tx_rp_reg[i]}];
        end
        tx_avail_o[i] <= (tx_cnt_next[i] != 16'h0000);
        rx_space_o[i] <= not_full(rx_cnt_next[i]);
      end
    end
  end

endmodule // cff_top

`default_nettype wire

/* File: dv/cff_top_monitor.sv */
// Checker for bus, serial handshake and reset behaviour of the FIFO block.
// Assumes it is bound to cff_top, one clock, synchronous reset.
`timescale 1ns/10ps
`default_nettype none
module cff_top_monitor (
  input wire        clk_i,
  input wire        rst_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        irq_o,
  input wire [3:0]  tx_pop_i,
  input wire [3:0]  tx_valid_o,
  input wire [3:0]  tx_avail_o,
  input wire [3:0]  rx_space_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Request taken, reset release, accepted pop, quiet outputs
  sequence take_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence quiet_s; !irq_o && tx_avail_o == 4'h0 && rx_space_o == 4'h0; endsequence
  sequence rel_s; rst_i ##1 !rst_i; endsequence
  sequence pop_s; tx_pop_i[0] && tx_avail_o[0]; endsequence
  ack_next_a: assert property (take_s |=> wb_ack_o)
    else $error("no ack after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  rst_clear_a: assert property (disable iff (1'b0) rst_i |=> quiet_s)
    else $error("reset left outputs set");
  rel_space_a: assert property (disable iff (1'b0) rel_s |=> rx_space_o == 4'hf)
    else $error("no space after reset");
  pop_ign_a: assert property (tx_pop_i[0] && !tx_avail_o[0] |=> !tx_valid_o[0])
    else $error("pop on empty gave data");
  pop_valid_a: assert property (pop_s |=> tx_valid_o[0])
    else $error("accepted pop gave no data");
  avail_rise_a: assert property ($rose(tx_avail_o[0]) |-> $past(wb_we_i))
    else $error("data appeared without a push");
endmodule // cff_top_monitor
bind cff_top cff_top_monitor mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o,
  .irq_o, .tx_pop_i, .tx_valid_o, .tx_avail_o, .rx_space_o);
`default_nettype wire

/* File: dv/cff_dma_model.sv */
// Serial DMA stand-in: drains transmit bytes, pushes receive bytes on call.
// Assumes the same clock as the FIFO block.
`timescale 1ns/10ps
`default_nettype none
module cff_dma_model (
  input  wire logic        clk_i,
  input  wire logic [3:0]  tx_valid_i,
  input  wire logic [31:0] tx_data_i,
  input  wire logic [3:0]  pop_en_i,
  output var  logic [3:0]  tx_pop_o,
  output var  logic [3:0]  rx_push_o,
  output var  logic [31:0] rx_data_o
);
  logic [7:0] got [$];
  initial begin
    tx_pop_o = 4'h0;
    rx_push_o = 4'h0;
    rx_data_o = 32'h0;
  end
  // Pop while enabled, keep channel 0 bytes as they arrive
  always @(posedge clk_i) begin
    tx_pop_o <= pop_en_i;
    if (tx_valid_i[0]) got.push_back(tx_data_i[7:0]);
  end
  // Push n counting bytes, then scramble the idle data lines
  task automatic push(input int ch, input int n, input logic [7:0] b0);
    for (int i = 0; i < n; i++) begin
      rx_push_o[ch] <= 1'b1;
      rx_data_o[8*ch +: 8] <= b0 + i[7:0];
      @(posedge clk_i);
    end
    rx_push_o <= 4'h0;
    rx_data_o <= ~rx_data_o;
  endtask
endmodule // cff_dma_model
`default_nettype wire

/* File: dv/cff_top_tb.sv */
// Self-checking bench: register, FIFO and interrupt traffic on channel 0.
// Assumes cff_top, the DMA stand-in model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module cff_top_tb;
  logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h0;
  logic [3:0]  wb_sel_i = 4'hf, pop_en = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, tx_data_o, rx_data_i, d;
  logic        wb_ack_o, irq_o;
  logic [3:0]  tx_pop_i, tx_valid_o, tx_avail_o, rx_push_i, rx_space_o;
  int          n_errors = 0, n_compared = 0;
  always #2 clk_i = ~clk_i;
  cff_top dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .irq_o, .tx_pop_i, .tx_data_o, .tx_valid_o, .tx_avail_o, .rx_push_i, .rx_data_i, .rx_space_o);
  cff_dma_model dma (.clk_i, .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .pop_en_i(pop_en),
    .tx_pop_o(tx_pop_i), .rx_push_o(rx_push_i), .rx_data_o(rx_data_i));
  // One classic bus cycle, held until ack, then one idle cycle
  task automatic bus(input logic we, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int t;
    t = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, wd};
    do begin @(posedge clk_i); t++; end while (wb_ack_o !== 1'b1 && t < 50);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    @(posedge clk_i);
    if (t >= 50) begin n_errors++; $display("CHECK FAILED %0t no ack", $time); end
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin n_errors++; $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v); bus(1'b1, a, v, d); endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e); bus(1'b0, a, 32'h0, d); chk(d, e); endtask
  task automatic finish_test;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin repeat (40000) @(posedge clk_i); n_errors++; finish_test; end
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rchk(12'h104, 32'h8000);
    rchk(12'h008, 32'h00070007);
    rchk(12'h004, 32'haa);
    rchk(12'h1f0, 32'h0);
    for (int i = 1; i <= 8; i++) begin
      wr(12'h000, 32'h10 + i);
      if (i >= 7) rchk(12'h004, i == 7 ? 32'hab : 32'haf);
    end
    rchk(12'h00c, 32'h8);
    wr(12'h008, 32'h7ff80008);
    rchk(12'h004, 32'ha3);
    wr(12'h008, 32'h00070007);
    wr(12'h108, 32'hffffffff);
    wr(12'h10c, 32'h1);
    pop_en <= 4'h1;
    repeat (12) @(posedge clk_i);
    pop_en <= 4'h0;
    rchk(12'h108, 32'h5);
    chk({31'h0, irq_o}, 32'h1);
    wr(12'h10c, 32'h0);
    @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    wr(12'h108, 32'h5);
    rchk(12'h108, 32'h0);
    for (int i = 0; i < 8; i++) chk({24'h0, dma.got[i]}, 32'h11 + i);
    // FIFO reset spares the partner FIFO
    wr(12'h000, 32'h55);
    dma.push(0, 2, 8'h60);
    wr(12'h004, 32'h100);
    rchk(12'h00c, 32'h0);
    rchk(12'h010, 32'h2);
    rchk(12'h000, 32'h60);
    rchk(12'h010, 32'h1);
    // Fill past capacity, extra bytes refused
    wr(12'h004, 32'h200);
    dma.push(0, 32770, 8'h00);
    rchk(12'h010, 32'h8000);
    rchk(12'h004, 32'h5a);
    // Board reset
    wr(12'h008, 32'h00030004);
    wr(12'h100, 32'h1);
    repeat (3) @(posedge clk_i);
    rchk(12'h010, 32'h0);
    rchk(12'h008, 32'h00070007);
    rchk(12'h104, 32'h8000);
    rchk(12'h004, 32'haa);
    finish_test;
  end
endmodule // cff_top_tb
`default_nettype wire
